// ==== rtl/abscan_host.sv ====
/*
 * tester-side controller for the analog boundary-scan cells: takes
 * orders over apb, drives tck/tms/tdi and samples tdo.
 * assumes: tdo is asynchronous to pclk; the device tap changes tdo on
 * the falling test clock and samples tms/tdi on the rising one.
 */
// Function
// - idle comparator: off one, mux, bandgap zero
// - idle converter: amplifier clock held zero
// - idle converter: amplifier path enable zero
// - idle converter: negative bandgap select zero
// - idle converter: converter power zero
// - idle converter: amplifier power zero
// - dac idle: top bit one, rest zero
// - idle converter: bypass channel connect one
// - idle converter: negative ground select zero
// - connectivity test needs no converter operation
// - all chains shift least significant first
`timescale 1ns/1ps
`default_nettype none

module abscan_host (
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, low active
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [abscan_pkg::ADDR_W-1:0] paddr, // apb address
   input wire logic [abscan_pkg::DATA_W-1:0] pwdata, // apb write data
   output logic [abscan_pkg::DATA_W-1:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   output logic tck, // test clock
   output logic tms, // test mode select
   output logic tdi, // test data to device
   input wire logic tdo // test data from device
);
   import abscan_pkg::*;

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d, pslverr_q, pslverr_d;
   logic ctrl_idle_q, ctrl_idle_d, done_q, done_d;
   logic dr_go_q, dr_go_d, ir_go_q, ir_go_d;
   logic [21:0] drive_q, drive_d;
   logic [3:0] ir_q, ir_d;
   abscan_state_t st_q, st_d;
   logic [2:0] ph_q, ph_d;
   logic [4:0] cnt_q, cnt_d;
   logic [21:0] sh_q, sh_d, capt_q, capt_d, vec_q, vec_d;
   logic run_ir_q, run_ir_d, idle_run_q, idle_run_d;
   logic tck_q, tck_d, tms_q, tms_d, tdi_q, tdi_d;
   logic tdo_m_q, tdo_s_q;
   logic acc, wr, busy, take_dr, take_ir, scan_end;
   logic [21:0] start_vec;

   // last bit index of the current scan
   function automatic logic [4:0] last_idx(input logic ir);
      return ir ? IR_LAST : DR_LAST;
   endfunction

   // offset lies in the register map
   function automatic logic mapped(input logic [7:0] a);
      return a == OFF_CTRL || a == OFF_DRIVE || a == OFF_IR ||
         a == OFF_STATUS || a == OFF_CAPT;
   endfunction

   // tms level to hold during a test clock step of the given state
   function automatic logic tms_of(input abscan_state_t s,
      input logic [4:0] c, input logic ir);
      logic t;
      t = 1'b0;
      case (s)
         S_RESET, S_SEL, S_SELIR, S_UPD: t = 1'b1;
         S_SHIFT: t = (c == last_idx(ir));
         default: t = 1'b0;
      endcase
      return t;
   endfunction

   // ----------------------------------------------------------------
   // apb slave and registers
   // ----------------------------------------------------------------
   // one wait state: ready rises the cycle after the access starts
   always_comb begin
      acc = psel && penable && !pready_q;
      wr = psel && penable && pready_q && pwrite && !pslverr_q;
      busy = (st_q != S_IDLE) || dr_go_q || ir_go_q;
      pready_d = acc;
      pslverr_d = acc && !mapped(paddr);
      prdata_d = prdata_q;
      ctrl_idle_d = ctrl_idle_q;
      drive_d = drive_q;
      ir_d = ir_q;
      dr_go_d = dr_go_q;
      ir_go_d = ir_go_q;
      done_d = done_q;
      if (acc && !pwrite) begin
         case (paddr)
            OFF_CTRL: prdata_d = {30'h0, ctrl_idle_q, 1'b0};
            OFF_DRIVE: prdata_d = {10'h000, drive_q};
            OFF_IR: prdata_d = {28'h0, ir_q};
            OFF_STATUS: prdata_d = {30'h0, done_q, busy};
            OFF_CAPT: prdata_d = {10'h000, capt_q};
            default: prdata_d = 32'h0;
         endcase
      end
      if (wr) begin
         case (paddr)
            OFF_CTRL: begin
               ctrl_idle_d = pwdata[CTRL_IDLE];
               if (!busy) begin
                  dr_go_d = pwdata[CTRL_DR_GO];
                  ir_go_d = pwdata[CTRL_IR_GO];
               end
            end
            OFF_DRIVE: drive_d = pwdata[21:0];
            OFF_IR: ir_d = pwdata[3:0];
            OFF_STATUS: if (pwdata[STAT_DONE]) done_d = 1'b0;
            default: done_d = done_d;
         endcase
      end
      if (take_dr) dr_go_d = 1'b0;
      if (take_ir) ir_go_d = 1'b0;
      // a scan ending in the clearing cycle still sets done
      if (scan_end) done_d = 1'b1;
   end

   // register the bus side
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         ctrl_idle_q <= CTRL_IDLE_RST;
         drive_q <= DRIVE_RST;
         ir_q <= IR_RST;
         dr_go_q <= 1'b0;
         ir_go_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         ctrl_idle_q <= ctrl_idle_d;
         drive_q <= drive_d;
         ir_q <= ir_d;
         dr_go_q <= dr_go_d;
         ir_go_q <= ir_go_d;
         done_q <= done_d;
      end
   end

   // ----------------------------------------------------------------
   // tdo synchroniser
   // ----------------------------------------------------------------
   // two flops before any logic looks at the device output
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tdo_m_q <= 1'b0;
         tdo_s_q <= 1'b0;
      end else begin
         tdo_m_q <= tdo;
         tdo_s_q <= tdo_m_q;
      end
   end

   // ----------------------------------------------------------------
   // tap sequencer
   // ----------------------------------------------------------------
   // one state step per test clock; pins change as tck falls, tdo is
   // taken in the last high phase, long after the device drove it
   always_comb begin
      st_d = st_q;
      ph_d = ph_q + 3'h1;
      cnt_d = cnt_q;
      sh_d = sh_q;
      capt_d = capt_q;
      vec_d = vec_q;
      run_ir_d = run_ir_q;
      idle_run_d = idle_run_q;
      tms_d = tms_q;
      tdi_d = tdi_q;
      take_dr = 1'b0;
      take_ir = 1'b0;
      scan_end = 1'b0;
      // idle mode forces the recommended inactive levels
      start_vec = IDLE_VEC;
      // otherwise software's vector; nothing here runs the converter
      if (!ctrl_idle_q) start_vec = drive_q & DRIVE_MASK;
      if (ph_q == PH_LAST) begin
         ph_d = 3'h0;
         case (st_q)
            S_RESET: begin
               cnt_d = cnt_q + 5'h01;
               if (cnt_q == TLR_LAST) begin
                  st_d = S_IDLE;
                  cnt_d = 5'h00;
               end
            end
            S_IDLE: begin
               if (ir_go_q || dr_go_q) begin
                  take_ir = ir_go_q;
                  take_dr = !ir_go_q;
                  st_d = S_SEL;
                  run_ir_d = ir_go_q;
                  idle_run_d = ctrl_idle_q && !ir_go_q;
                  vec_d = start_vec;
                  sh_d = ir_go_q ? {18'h00000, ir_q} : start_vec;
               end
            end
            S_SEL: st_d = run_ir_q ? S_SELIR : S_CAP;
            S_SELIR: st_d = S_CAP;
            // leaving capture loads the cells with what they observe
            S_CAP: st_d = S_ENTER;
            S_ENTER: st_d = S_SHIFT;
            S_SHIFT: begin
               // bit 0 leaves first, device bits enter from the top
               sh_d = {tdo_s_q, sh_q[21:1]};
               cnt_d = cnt_q + 5'h01;
               if (cnt_q == last_idx(run_ir_q)) begin
                  st_d = S_UPD;
                  cnt_d = 5'h00;
               end
            end
            S_UPD: begin
               // update step moves the shifted bits to the latches
               st_d = S_IDLE;
               scan_end = 1'b1;
               if (!run_ir_q) capt_d = sh_q;
            end
            default: st_d = S_IDLE;
         endcase
         tms_d = tms_of(st_d, cnt_d, run_ir_d);
         tdi_d = (st_d == S_SHIFT) ? sh_d[0] : 1'b0;
      end
      tck_d = (ph_d >= PH_RISE);
   end

   // register the tap side; the tap is walked to reset after presetn
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= S_RESET;
         ph_q <= 3'h0;
         cnt_q <= 5'h00;
         sh_q <= 22'h000000;
         capt_q <= 22'h000000;
         vec_q <= 22'h000000;
         run_ir_q <= 1'b0;
         idle_run_q <= 1'b0;
         tck_q <= 1'b0;
         tms_q <= 1'b1;
         tdi_q <= 1'b0;
      end else begin
         st_q <= st_d;
         ph_q <= ph_d;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
         capt_q <= capt_d;
         vec_q <= vec_d;
         run_ir_q <= run_ir_d;
         idle_run_q <= idle_run_d;
         tck_q <= tck_d;
         tms_q <= tms_d;
         tdi_q <= tdi_d;
      end
   end

   // outputs straight from flops
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign tck = tck_q;
   assign tms = tms_q;
   assign tdi = tdi_q;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // data bit on tdi while a data scan is shifting
   logic dr_bit;
   assign dr_bit = st_q == S_SHIFT && !run_ir_q && ph_q == 3'h1;

   a_cmp_idle_bits: assert property (
      dr_bit && idle_run_q && cnt_q >= POS_CMP_OFF &&
      cnt_q <= POS_CMP_BG |-> tdi_q == (cnt_q == POS_CMP_OFF))
      else $error("comparator idle bits wrong");
   a_amp_clk_idle: assert property (
      dr_bit && idle_run_q && cnt_q == POS_AMP_CLK |->
      (!tdi_q && !tck_q) [*3])
      else $error("amplifier clock not held low");
   a_amp_path_idle: assert property (
      dr_bit && idle_run_q && cnt_q == POS_AMP_PATH |->
      !tdi_q ##3 (tck_q && !tdi_q))
      else $error("amplifier path enable not low");
   a_neg_bg_idle: assert property (
      dr_bit && idle_run_q && cnt_q == POS_NEG_BG |->
      !tdi_q ##1 $stable(tdi_q))
      else $error("negative bandgap select not low");
   a_conv_pwr_idle: assert property (
      dr_bit && idle_run_q && cnt_q == POS_CONV_PWR |-> !tdi_q [*6])
      else $error("converter power not low");
   a_amp_pwr_idle: assert property (
      dr_bit && idle_run_q && cnt_q == POS_AMP_PWR |->
      !tdi_q && !tms_q)
      else $error("amplifier power not low");
   a_dac_idle_code: assert property (
      dr_bit && idle_run_q && cnt_q >= POS_DAC0 && cnt_q <= POS_DAC9
      |-> tdi_q == (cnt_q == POS_DAC9))
      else $error("dac idle code wrong");
   a_bypass_idle: assert property (
      dr_bit && idle_run_q && cnt_q == POS_BYPASS |->
      tdi_q ##3 (tck_q && tdi_q))
      else $error("bypass connect not high");
   a_gnd_idle_last: assert property (
      dr_bit && idle_run_q && cnt_q == POS_GND |-> !tdi_q && tms_q)
      else $error("ground select not low on last bit");
   a_lsb_first_out: assert property (
      dr_bit |-> tdi_q == vec_q[cnt_q])
      else $error("chain not shifted lsb first");

   // tms and tdi move only as tck falls, so the tap samples them settled
   a_pins_on_fall: assert property (
      $changed(tms_q) || $changed(tdi_q) |-> $fell(tck_q))
      else $error("tap pins moved off the falling test clock");

   // a scan end wins over a software clear in the same cycle
   a_done_set_wins: assert property (
      scan_end |=> done_q)
      else $error("done lost at scan end");

   c_idle_scan: cover property (scan_end && idle_run_q);
   c_user_scan: cover property (scan_end && !run_ir_q && !idle_run_q);
   c_ir_scan: cover property (scan_end && run_ir_q);
   c_go_busy: cover property (wr && paddr == OFF_CTRL && busy);

endmodule

`default_nettype wire

// ==== rtl/abscan_pkg.sv ====
/*
 * constants, register map and state type for the analog boundary-scan
 * host controller.
 * assumes: a 50 MHz pclk and an external tap whose chain segment for the
 * comparator and converter cells is laid out as given here.
 */
package abscan_pkg;

   // ----------------------------------------------------------------
   // register bus
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_DRIVE = 8'h04;
   localparam logic [7:0] OFF_IR = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0C;
   localparam logic [7:0] OFF_CAPT = 8'h10;
   localparam int CTRL_DR_GO = 0;
   localparam int CTRL_IDLE = 1;
   localparam int CTRL_IR_GO = 2;
   localparam int STAT_BUSY = 0;
   localparam int STAT_DONE = 1;

   // ----------------------------------------------------------------
   // chain segment, position 0 is shifted first
   // ----------------------------------------------------------------
   localparam int CHAIN_LEN = 22;
   localparam int IR_LEN = 4;
   localparam logic [4:0] POS_CMP_RESULT = 5'h00;
   localparam logic [4:0] POS_CMP_OFF = 5'h01;
   localparam logic [4:0] POS_CMP_MUX = 5'h02;
   localparam logic [4:0] POS_CMP_BG = 5'h03;
   localparam logic [4:0] POS_CONV_RESULT = 5'h04;
   localparam logic [4:0] POS_AMP_CLK = 5'h05;
   localparam logic [4:0] POS_AMP_PATH = 5'h06;
   localparam logic [4:0] POS_NEG_BG = 5'h07;
   localparam logic [4:0] POS_CONV_PWR = 5'h08;
   localparam logic [4:0] POS_AMP_PWR = 5'h09;
   localparam logic [4:0] POS_DAC0 = 5'h0A;
   localparam logic [4:0] POS_DAC9 = 5'h13;
   localparam logic [4:0] POS_BYPASS = 5'h14;
   localparam logic [4:0] POS_GND = 5'h15;
   localparam logic [4:0] DR_LAST = 5'(CHAIN_LEN - 1);
   localparam logic [4:0] IR_LAST = 5'(IR_LEN - 1);

   // recommended inactive vector and the bits software may drive
   localparam logic [21:0] IDLE_VEC = 22'h180002;
   localparam logic [21:0] DRIVE_MASK = 22'h3FFFEE;
   localparam logic [21:0] DRIVE_RST = IDLE_VEC;
   localparam logic [3:0] IR_RST = 4'h0;
   localparam logic CTRL_IDLE_RST = 1'b1;

   // ----------------------------------------------------------------
   // test clock timing
   // ----------------------------------------------------------------
   localparam int CLK_NS = 20;
   localparam int TCK_PERIOD_NS = 160;
   localparam int TCK_CYC = TCK_PERIOD_NS / CLK_NS;
   localparam logic [2:0] PH_LAST = 3'(TCK_CYC - 1);
   localparam logic [2:0] PH_RISE = 3'(TCK_CYC / 2);
   localparam logic [4:0] TLR_LAST = 5'h04;

   typedef enum logic [2:0] {
      S_IDLE = 3'h0,
      S_RESET = 3'h1,
      S_SEL = 3'h2,
      S_SELIR = 3'h3,
      S_CAP = 3'h4,
      S_ENTER = 3'h5,
      S_SHIFT = 3'h6,
      S_UPD = 3'h7
   } abscan_state_t;

endpackage

// ==== verification/abscan_dev_model.sv ====
/*
 * device side of the test access port: tap state machine, 4-bit
 * instruction register, the 22-cell analog boundary segment and a one-bit
 * bypass register.
 * assumes: tms/tdi are sampled on rising tck; tdo changes on falling tck.
 */
`timescale 1ns/1ps
`default_nettype none

module abscan_dev_model (
   input wire logic tck, // test clock from host
   input wire logic tms, // test mode select
   input wire logic tdi, // test data from host
   output logic tdo, // test data to host
   input wire logic [21:0] sys_vec // values the core and analog side show
);
   // ----------------------------------------------------------------
   // tap states
   // ----------------------------------------------------------------
   localparam logic [3:0] TLR = 4'h0, RTI = 4'h1, SDR = 4'h2, CDR = 4'h3;
   localparam logic [3:0] SHD = 4'h4, E1D = 4'h5, PDR = 4'h6, E2D = 4'h7;
   localparam logic [3:0] UDR = 4'h8, SIR = 4'h9, CIR = 4'hA, SHI = 4'hB;
   localparam logic [3:0] E1I = 4'hC, PIR = 4'hD, E2I = 4'hE, UIR = 4'hF;
   logic [3:0] st_q = TLR;
   logic [3:0] ir_q = 4'h1;
   logic [3:0] ir_sr = 4'h0;
   logic [21:0] sr = 22'h0;
   logic [21:0] latch_q = 22'h0;
   logic byp = 1'b0;
   int upd_cnt = 0;
   logic bnd;
   initial tdo = 1'b0;

   // boundary segment selected by the two boundary opcodes
   assign bnd = (ir_q == 4'h0) || (ir_q == 4'h2);

   function automatic logic [3:0] nxt(input logic [3:0] s, input logic m);
      case (s)
         TLR: nxt = m ? TLR : RTI;
         SDR: nxt = m ? SIR : CDR;
         CDR, SHD: nxt = m ? E1D : SHD;
         E1D: nxt = m ? UDR : PDR;
         PDR: nxt = m ? E2D : PDR;
         E2D: nxt = m ? UDR : SHD;
         SIR: nxt = m ? TLR : CIR;
         CIR, SHI: nxt = m ? E1I : SHI;
         E1I: nxt = m ? UIR : PIR;
         PIR: nxt = m ? E2I : PIR;
         E2I: nxt = m ? UIR : SHI;
         default: nxt = m ? SDR : RTI;
      endcase
   endfunction

   // capture and shift on rising tck, lsb leaves first
   always @(posedge tck) begin
      if (st_q == CDR && bnd) sr <= sys_vec;
      if (st_q == CDR) byp <= 1'b0;
      if (st_q == SHD && bnd) sr <= {tdi, sr[21:1]};
      if (st_q == SHD) byp <= tdi;
      if (st_q == CIR) ir_sr <= 4'h1;
      if (st_q == SHI) ir_sr <= {tdi, ir_sr[3:1]};
      if (st_q == TLR) ir_q <= 4'h1;
      st_q <= nxt(st_q, tms);
   end

   // update latches and drive tdo on falling tck; tdo toggles when idle
   always @(negedge tck) begin
      if (st_q == UDR && bnd) begin
         latch_q <= sr;
         upd_cnt <= upd_cnt + 1;
      end
      if (st_q == UIR) ir_q <= ir_sr;
      if (st_q == SHD) tdo <= bnd ? sr[0] : byp;
      else if (st_q == SHI) tdo <= ir_sr[0];
      else tdo <= ~tdo;
   end
endmodule

`default_nettype wire

// ==== verification/test_abscan_host.sv ====
/*
 * self-checking bench for the analog boundary-scan host controller.
 * assumes: the device model answers on tck/tms/tdi/tdo; apb registers
 * and chain order as in abscan_pkg.
 */
`timescale 1ns/1ps
`default_nettype none

module test_abscan_host;
   import abscan_pkg::*;
   logic pclk = 1'b0;
   logic presetn, psel, penable, pwrite, pready, pslverr, tck, tms, tdi, tdo;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, wdat;
   logic [21:0] sys_vec, drv;
   logic err;
   int bad_count = 0;
   int compares = 0;
   int cyc = 0;
   int cnt;

   always #10 pclk = ~pclk;

   abscan_host i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .tck(tck),
      .tms(tms), .tdi(tdi), .tdo(tdo));
   abscan_dev_model i_dev (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
      .sys_vec(sys_vec));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic stop_test();
      if (bad_count == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // wait for a free sequencer (a go while busy is dropped), start a
   // scan, poll until done with busy low (ir then dr), then clear done
   task automatic scan(input logic [31:0] ctrl);
      int n;
      n = 0;
      rd = 32'h1;
      while (rd[STAT_BUSY] !== 1'b0 && n < 400) begin
         apb(1'b0, OFF_STATUS, 32'h0);
         n++;
      end
      apb(1'b1, OFF_CTRL, ctrl);
      n = 0;
      rd = 32'h0;
      while (rd[1:0] !== 2'b10 && n < 400) begin
         apb(1'b0, OFF_STATUS, 32'h0);
         n++;
      end
      chk(rd, 32'h2);
      apb(1'b1, OFF_STATUS, 32'h2);
      apb(1'b0, OFF_STATUS, 32'h0);
      chk(rd, 32'h0);
   endtask

   // recommended inactive values of every cell
   function automatic logic [21:0] idle_vec();
      logic [21:0] v;
      v = 22'h0;
      v[1] = 1'b1;
      v[19] = 1'b1;
      v[20] = 1'b1;
      return v;
   endfunction

   // observe-only positions go out as zero
   function automatic logic [21:0] sent_vec(input logic [21:0] d);
      logic [21:0] v;
      v = d;
      v[POS_CMP_RESULT] = 1'b0;
      v[POS_CONV_RESULT] = 1'b0;
      return v;
   endfunction

   // cut a hang short
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 40000) begin
         bad_count++;
         stop_test();
      end
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      sys_vec = 22'h0;
      void'($urandom(11915));
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      // reset values and two unmapped addresses, one read and one written
      apb(1'b0, OFF_CTRL, 32'h0);
      chk(rd, 32'h2);
      apb(1'b0, OFF_DRIVE, 32'h0);
      chk(rd, {10'h0, idle_vec()});
      apb(1'b0, OFF_IR, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h14, 32'h0);
      chk({rd[30:0], err}, 32'h1);
      apb(1'b1, 8'h18, 32'h5);
      chk({31'h0, err}, 32'h1);
      // ir then dr in one order, idle mode
      sys_vec <= 22'($urandom);
      scan(32'h7);
      chk({28'h0, i_dev.ir_q}, 32'h0);
      chk({10'h0, i_dev.latch_q}, {10'h0, idle_vec()});
      apb(1'b0, OFF_CAPT, 32'h0);
      chk(rd, {10'h0, sys_vec});
      // an all-ones drive vector then random ones, software values
      for (int i = 0; i < 6; i++) begin
         drv = (i == 0) ? 22'h3FFFFF : 22'($urandom);
         sys_vec <= 22'($urandom);
         wdat = {$urandom} | 32'(drv);
         apb(1'b1, OFF_DRIVE, wdat);
         apb(1'b0, OFF_DRIVE, 32'h0);
         chk(rd, {10'h0, wdat[21:0]});
         drv = wdat[21:0];
         scan(32'h1);
         chk({10'h0, i_dev.latch_q}, {10'h0, sent_vec(drv)});
         apb(1'b0, OFF_CAPT, 32'h0);
         chk(rd, {10'h0, sys_vec});
      end
      // bypass instruction: no update, captured data delayed one cell
      apb(1'b1, OFF_IR, 32'hF);
      cnt = i_dev.upd_cnt;
      scan(32'h5);
      chk({28'h0, i_dev.ir_q}, 32'hF);
      chk(32'(i_dev.upd_cnt), 32'(cnt));
      apb(1'b0, OFF_CAPT, 32'h0);
      drv = sent_vec(drv);
      chk(rd, {10'h0, drv[20:0], 1'b0});
      // ir scan alone
      apb(1'b1, OFF_IR, 32'h2);
      scan(32'h4);
      chk({28'h0, i_dev.ir_q}, 32'h2);
      // a go written while busy is dropped
      cnt = i_dev.upd_cnt;
      apb(1'b1, OFF_CTRL, 32'h3);
      rd = 32'h0;
      for (int n = 0; n < 40 && rd[STAT_BUSY] !== 1'b1; n++)
         apb(1'b0, OFF_STATUS, 32'h0);
      apb(1'b1, OFF_CTRL, 32'h3);
      scan(32'h0);
      repeat (400) @(posedge pclk);
      chk(32'(i_dev.upd_cnt), 32'(cnt + 1));
      chk({10'h0, i_dev.latch_q}, {10'h0, idle_vec()});
      stop_test();
   end
endmodule

`default_nettype wire
